// ===== core/ebi_core.v
`timescale 1ns/1ns
`include "ebi_consts.vh"
// Function
// [RL1] Width pin low 16 bit, high 8 bit
// [RL2] Board holds width pin fixed
// [RL3] Upper byte lanes used only on 16-bit bus
// [RL4] Twenty address lines driven out
// [RL5] 8-bit mux: A0-A7 then D0-D7
// [RL6] 16-bit mux: A1-A8 then D0-D7
// [RL7] Four active-low chip selects per area
// [RL8] Split scheme: low even, high odd writes
// [RL9] Read strobe low during reads
// [RL10] Combined scheme: one write, byte-high on odd
// [RL11] Software picks combined scheme on 8 bit
// [RL12] Address latch strobe output for capture
// [RL13] Hold request pin kept high by board
// [RL14] Hold acknowledge low during hold
// [RL15] Wait input low stretches bus cycle
// [RL16] Mode pin picks start mode after reset
// [RL17] Low reset pin resets the block
// [RL18] Mode field 00 single, 01 expand, 11 micro
// [RL19] Strobes idle outside active external accesses
// [RL20] Address held through latch strobe end
module ebi_core (
    input wire clk_i,
    input wire rst_i,
    input wire ext_reset_n_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire width_select_i,
    input wire mode_select_pin_i,
    input wire wait_request_n_i,
    input wire bus_hold_request_n_i,
    input wire [15:0] data_i,
    output wire [15:0] data_o,
    output wire [1:0] data_oe_o,
    output wire [19:0] addr_o,
    output wire [3:0] chip_select_n_o,
    output wire write_low_strobe_n_o,
    output wire write_high_strobe_n_o,
    output wire read_strobe_n_o,
    output wire addr_latch_strobe_o,
    output wire hold_ack_out_n_o
);
    // ****************************************
    // States
    // ****************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_LATCH = 3'h1;
    localparam ST_AHOLD = 3'h2;
    localparam ST_STROBE = 3'h3;
    localparam ST_END = 3'h4;
    localparam ST_HOLD = 3'h5;

    // ****************************************
    // Pin synchronisers and reset
    // ****************************************
    wire reset_pin_n;
    wire width8;
    wire mode_pin;
    wire wait_n;
    wire hold_req_n;
    wire rst_all;

    ebi_sync #(.INIT(1'b1)) u_rst (.clk_i(clk_i), .rst_i(rst_i),
        .pin_i(ext_reset_n_i), .level_o(reset_pin_n));
    ebi_sync #(.INIT(1'b0)) u_width (.clk_i(clk_i), .rst_i(rst_i),
        .pin_i(width_select_i), .level_o(width8)); // RL1
    ebi_sync #(.INIT(1'b0)) u_mode (.clk_i(clk_i), .rst_i(rst_i),
        .pin_i(mode_select_pin_i), .level_o(mode_pin));
    ebi_sync #(.INIT(1'b1)) u_wait (.clk_i(clk_i), .rst_i(rst_i),
        .pin_i(wait_request_n_i), .level_o(wait_n));
    ebi_sync #(.INIT(1'b1)) u_hold (.clk_i(clk_i), .rst_i(rst_i),
        .pin_i(bus_hold_request_n_i), .level_o(hold_req_n));

    // Bus reset also follows the external reset pin
    assign rst_all = rst_i | ~reset_pin_n; // RL17

    // ****************************************
    // Registers
    // ****************************************
    reg [1:0] pm_q;
    reg scheme_q;
    reg mux_q;
    reg [2:0] strap_cnt_q;
    reg strap_done_q;
    reg [3:0] csen_q;
    reg [19:0] acc_addr_q;
    reg [15:0] wdata_q;
    reg [15:0] rdata_q;
    reg acc_write_q;
    reg acc_word_q;
    reg done_q;
    reg refused_q;
    reg ack_q;
    reg [31:0] rd_q;
    reg [2:0] st_q;
    reg second_q;
    reg [19:0] addr_q;
    reg [15:0] dout_q;
    reg [1:0] oe_q;
    reg [3:0] cs_n_q;
    reg wrl_n_q;
    reg wrh_n_q;
    reg rd_n_q;
    reg ale_q;
    reg hold_ack_out_n_q;

    wire bus_on;
    wire wb_req;
    wire wb_wr;
    wire [7:0] reg_off;
    wire start_req;

    // External bus is live only outside single-chip mode
    assign bus_on = (pm_q != `EBI_PM_SINGLE); // RL18
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wb_wr = wb_req & wb_we_i;
    assign reg_off = {wb_adr_i[7:2], 2'h0};
    assign start_req = wb_wr & wb_sel_i[0] & (reg_off == `EBI_REG_CMD) &
        wb_dat_i[`EBI_CMD_START_BIT];

    // Chip select decode from the top two address bits
    function [3:0] cs_decode;
        input [19:0] a;
        input [3:0] en;
        begin
            cs_decode = ~((4'h1 << a[19:18]) & en);
        end
    endfunction

    // Byte address of the current beat
    function [19:0] beat_addr;
        input [19:0] a;
        input second;
        begin
            beat_addr = second ? (a | 20'h00001) : a;
        end
    endfunction

    // ****************************************
    // Wishbone slave
    // ****************************************
    // One-cycle registered answer, ack drops after one cycle
    always @(posedge clk_i) begin
        if (rst_all) begin
            ack_q <= 1'b0;
            rd_q <= 32'h00000000;
        end else begin
            ack_q <= wb_req;
            rd_q <= 32'h00000000;
            if (wb_req & ~wb_we_i) begin
                case (reg_off)
                    `EBI_REG_MODE: rd_q <= {28'h0000000, mux_q, scheme_q, pm_q};
                    `EBI_REG_CSEN: rd_q <= {28'h0000000, csen_q};
                    `EBI_REG_ADDR: rd_q <= {12'h000, acc_addr_q};
                    `EBI_REG_WDATA: rd_q <= {16'h0000, wdata_q};
                    `EBI_REG_CMD: rd_q <= {29'h00000000, acc_word_q, acc_write_q, 1'b0};
                    `EBI_REG_STATUS: rd_q <= {26'h0000000, refused_q, done_q,
                        ~wait_n & (st_q == ST_STROBE), (st_q == ST_HOLD), width8,
                        (st_q != ST_IDLE)};
                    `EBI_REG_RDATA: rd_q <= {16'h0000, rdata_q};
                    default: rd_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Configuration writes and start-up mode capture
    always @(posedge clk_i) begin
        if (rst_all) begin
            pm_q <= `EBI_PM_SINGLE;
            scheme_q <= 1'b0;
            mux_q <= 1'b0;
            strap_cnt_q <= 3'h0;
            strap_done_q <= 1'b0;
            csen_q <= `EBI_CSEN_RST;
            acc_addr_q <= 20'h00000;
            wdata_q <= 16'h0000;
            acc_write_q <= 1'b0;
            acc_word_q <= 1'b0;
        end else begin
            // Mode pin taken only once its synchroniser shows the pin
            if (!strap_done_q) begin
                strap_cnt_q <= strap_cnt_q + 3'h1;
                if (strap_cnt_q == `EBI_STRAP_WAIT) begin
                    strap_done_q <= 1'b1;
                    pm_q <= mode_pin ? `EBI_PM_MICRO : `EBI_PM_SINGLE; // RL16
                end
            end
            if (wb_wr & wb_sel_i[0]) begin
                case (reg_off)
                    `EBI_REG_MODE: begin
                        if (wb_dat_i[1:0] != `EBI_PM_RSVD) begin
                            pm_q <= wb_dat_i[1:0]; // RL18
                        end
                        scheme_q <= wb_dat_i[`EBI_MODE_SCHEME_BIT];
                        mux_q <= wb_dat_i[`EBI_MODE_MUX_BIT];
                    end
                    `EBI_REG_CSEN: csen_q <= wb_dat_i[3:0];
                    `EBI_REG_CMD: begin
                        if (st_q == ST_IDLE) begin
                            acc_write_q <= wb_dat_i[`EBI_CMD_WRITE_BIT];
                            acc_word_q <= wb_dat_i[`EBI_CMD_WORD_BIT];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (wb_wr & (reg_off == `EBI_REG_ADDR)) begin
                if (wb_sel_i[0]) acc_addr_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) acc_addr_q[15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2]) acc_addr_q[19:16] <= wb_dat_i[19:16];
            end
            if (wb_wr & (reg_off == `EBI_REG_WDATA)) begin
                if (wb_sel_i[0]) wdata_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) wdata_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ****************************************
    // Bus cycle sequencer
    // ****************************************
    wire [19:0] cur_addr;
    wire odd;
    wire wide;
    wire two_lanes;
    wire [7:0] mux_addr;
    wire done_set;
    wire done_clr;

    assign cur_addr = beat_addr(acc_addr_q, second_q);
    assign odd = cur_addr[0];
    // Word on a 16-bit bus at even address moves both lanes at once
    assign wide = ~width8; // RL1
    assign two_lanes = wide & acc_word_q & ~odd; // RL3
    // Shared lines carry A0-A7 on 8-bit, A1-A8 on 16-bit
    assign mux_addr = width8 ? cur_addr[7:0] : cur_addr[8:1]; // RL5 RL6
    assign done_set = (st_q == ST_END) & ~(acc_word_q & width8 & ~second_q);
    assign done_clr = wb_req & ~wb_we_i & (reg_off == `EBI_REG_STATUS);

    // Sticky done and refused flags; a new event wins over the read clear
    always @(posedge clk_i) begin
        if (rst_all) begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (done_set) begin
                done_q <= 1'b1;
            end else if (done_clr) begin
                done_q <= 1'b0;
            end
            if (start_req & (~bus_on | (st_q != ST_IDLE))) begin
                refused_q <= 1'b1;
            end else if (done_clr) begin
                refused_q <= 1'b0;
            end
        end
    end

    // Pin-level state machine
    always @(posedge clk_i) begin
        if (rst_all) begin
            st_q <= ST_IDLE;
            second_q <= 1'b0;
            rdata_q <= 16'h0000;
            addr_q <= 20'h00000;
            dout_q <= 16'h0000;
            oe_q <= 2'h0;
            cs_n_q <= 4'hF;
            wrl_n_q <= 1'b1;
            wrh_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            ale_q <= 1'b0;
            hold_ack_out_n_q <= 1'b1;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    // Strobes and selects idle between accesses
                    cs_n_q <= 4'hF; // RL19
                    wrl_n_q <= 1'b1;
                    wrh_n_q <= 1'b1;
                    rd_n_q <= 1'b1;
                    oe_q <= 2'h0;
                    ale_q <= 1'b0;
                    second_q <= 1'b0;
                    if (bus_on & ~hold_req_n) begin
                        st_q <= ST_HOLD;
                        hold_ack_out_n_q <= 1'b0; // RL14
                    end else if (start_req & bus_on) begin
                        st_q <= ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    addr_q <= cur_addr; // RL4
                    cs_n_q <= cs_decode(cur_addr, csen_q); // RL7
                    ale_q <= 1'b1; // RL12
                    if (mux_q) begin
                        dout_q <= {8'h00, mux_addr}; // RL5 RL6
                        oe_q <= 2'h1;
                    end
                    st_q <= ST_AHOLD;
                end
                ST_AHOLD: begin
                    // Latch strobe falls on the same edge that takes the address off the shared lines
                    ale_q <= 1'b0; // RL20
                    st_q <= ST_STROBE;
                    if (acc_write_q) begin
                        if (width8) begin
                            dout_q <= {8'h00, second_q ? wdata_q[15:8] : wdata_q[7:0]};
                            oe_q <= 2'h1;
                        end else if (two_lanes) begin
                            dout_q <= wdata_q;
                            oe_q <= 2'h3;
                        end else if (odd) begin
                            dout_q <= {wdata_q[7:0], 8'h00}; // RL3
                            oe_q <= 2'h2;
                        end else begin
                            dout_q <= {8'h00, wdata_q[7:0]};
                            oe_q <= 2'h1;
                        end
                    end else begin
                        oe_q <= 2'h0;
                    end
                    if (~acc_write_q) begin
                        rd_n_q <= 1'b0; // RL9
                        wrh_n_q <= ~(scheme_q & (odd | two_lanes)); // RL10
                    end else if (scheme_q) begin
                        wrl_n_q <= 1'b0; // RL10
                        wrh_n_q <= ~(odd | two_lanes); // RL10
                    end else begin
                        wrl_n_q <= ~(~odd | width8); // RL8
                        wrh_n_q <= ~(wide & (odd | two_lanes)); // RL8
                    end
                end
                ST_STROBE: begin
                    // Stay while wait input is low
                    if (wait_n) begin // RL15
                        st_q <= ST_END;
                        wrl_n_q <= 1'b1;
                        wrh_n_q <= 1'b1;
                        rd_n_q <= 1'b1;
                        if (~acc_write_q) begin
                            if (width8) begin
                                if (second_q) rdata_q[15:8] <= data_i[7:0];
                                else rdata_q <= {8'h00, data_i[7:0]};
                            end else if (two_lanes) begin
                                rdata_q <= data_i;
                            end else begin
                                rdata_q <= {8'h00, odd ? data_i[15:8] : data_i[7:0]};
                            end
                        end
                    end
                end
                ST_END: begin
                    cs_n_q <= 4'hF; // RL19
                    oe_q <= 2'h0;
                    if (acc_word_q & width8 & ~second_q) begin
                        second_q <= 1'b1;
                        st_q <= ST_LATCH;
                    end else begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    if (hold_req_n) begin
                        hold_ack_out_n_q <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_dat_o = rd_q;
    assign wb_ack_o = ack_q;
    assign data_o = dout_q;
    assign data_oe_o = oe_q;
    assign addr_o = addr_q;
    assign chip_select_n_o = cs_n_q;
    assign write_low_strobe_n_o = wrl_n_q;
    assign write_high_strobe_n_o = wrh_n_q;
    assign read_strobe_n_o = rd_n_q;
    assign addr_latch_strobe_o = ale_q;
    assign hold_ack_out_n_o = hold_ack_out_n_q;
endmodule

// ===== pkg/ebi_consts.vh
`ifndef EBI_CONSTS_VH
`define EBI_CONSTS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define EBI_REG_MODE 8'h00
`define EBI_REG_CSEN 8'h04
`define EBI_REG_ADDR 8'h08
`define EBI_REG_WDATA 8'h0C
`define EBI_REG_CMD 8'h10
`define EBI_REG_STATUS 8'h14
`define EBI_REG_RDATA 8'h18
// ****************************************
// Field positions
// ****************************************
`define EBI_MODE_SCHEME_BIT 2
`define EBI_MODE_MUX_BIT 3
`define EBI_CMD_START_BIT 0
`define EBI_CMD_WRITE_BIT 1
`define EBI_CMD_WORD_BIT 2
`define EBI_ST_BUSY_BIT 0
`define EBI_ST_WIDTH8_BIT 1
`define EBI_ST_HOLD_BIT 2
`define EBI_ST_WAIT_BIT 3
`define EBI_ST_DONE_BIT 4
`define EBI_ST_REFUSED_BIT 5
// ****************************************
// Processor mode encodings
// ****************************************
`define EBI_PM_SINGLE 2'h0
`define EBI_PM_EXPAND 2'h1
`define EBI_PM_RSVD 2'h2
`define EBI_PM_MICRO 2'h3
// ****************************************
// Reset values and timing
// ****************************************
`define EBI_CSEN_RST 4'h1
`define EBI_STRAP_WAIT 3'h4 // Past the mode synchroniser's flush
`endif

// ===== core/ebi_sync.v
`timescale 1ns/1ns
// ****************************************
// Three-stage pin synchroniser
// ****************************************
module ebi_sync #(
    parameter INIT = 1'b0
) (
    input wire clk_i,
    input wire rst_i,
    input wire pin_i,
    output wire level_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg level_q;

    // Stage chain; output follows once stages two and three agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            level_q <= INIT;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign level_o = level_q;
endmodule

// ===== tb/ebi_core_sva.sv
`timescale 1ns/1ns
// ****
// Pin behaviour checker
// ****
module ebi_core_sva (
    input wire clk_i,
    input wire rst_i,
    input wire ext_reset_n_i,
    input wire width_select_i,
    input wire wait_request_n_i,
    input wire bus_hold_request_n_i,
    input wire [1:0] data_oe_o,
    input wire [19:0] addr_o,
    input wire [3:0] chip_select_n_o,
    input wire write_low_strobe_n_o,
    input wire read_strobe_n_o,
    input wire addr_latch_strobe_o,
    input wire hold_ack_out_n_o
);
    // One domain, reset disables all
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Address phase start and stalled read
    sequence s_ale;
        $rose(addr_latch_strobe_o);
    endsequence
    sequence s_stall;
        (!read_strobe_n_o && !wait_request_n_i) [*5];
    endsequence
    property p_cs_area;
        chip_select_n_o != 4'hF |-> ~chip_select_n_o == (4'h1 << addr_o[19:18]);
    endproperty
    a_cs_area: assert property (p_cs_area) else $error("chip select off area");
    property p_idle;
        !read_strobe_n_o || !write_low_strobe_n_o |-> chip_select_n_o != 4'hF;
    endproperty
    a_idle: assert property (p_idle) else $error("strobe without select");
    property p_rd_excl;
        !read_strobe_n_o |-> write_low_strobe_n_o;
    endproperty
    a_rd_excl: assert property (p_rd_excl) else $error("read and write together");
    property p_ale;
        s_ale |=> !addr_latch_strobe_o && $stable(addr_o);
    endproperty
    a_ale: assert property (p_ale) else $error("latch pulse or address wrong");
    property p_ale_quiet;
        addr_latch_strobe_o |-> read_strobe_n_o && write_low_strobe_n_o;
    endproperty
    a_ale_quiet: assert property (p_ale_quiet) else $error("strobe in address phase");
    property p_stall;
        s_stall |=> !read_strobe_n_o;
    endproperty
    a_stall: assert property (p_stall) else $error("strobe ended during wait");
    property p_hold_bus;
        !hold_ack_out_n_o |-> chip_select_n_o == 4'hF && read_strobe_n_o;
    endproperty
    a_hold_bus: assert property (p_hold_bus) else $error("bus active in hold");
    property p_hold_rel;
        bus_hold_request_n_i [*8] |=> hold_ack_out_n_o;
    endproperty
    a_hold_rel: assert property (p_hold_rel) else $error("hold ack without request");
    property p_ext_rst;
        !ext_reset_n_i [*8] |-> chip_select_n_o == 4'hF && !addr_latch_strobe_o;
    endproperty
    a_ext_rst: assert property (p_ext_rst) else $error("bus active in pin reset");
    property p_lane8;
        width_select_i [*8] |-> !data_oe_o[1];
    endproperty
    a_lane8: assert property (p_lane8) else $error("upper lane on narrow bus");
endmodule
bind ebi_core ebi_core_sva u_ebi_core_sva (.clk_i, .rst_i, .ext_reset_n_i, .width_select_i,
    .wait_request_n_i, .bus_hold_request_n_i, .data_oe_o, .addr_o, .chip_select_n_o,
    .write_low_strobe_n_o, .read_strobe_n_o, .addr_latch_strobe_o, .hold_ack_out_n_o);

// ===== tb/ebi_far_mem.sv
`timescale 1ns/1ns
// ****
// Far-side memory model
// ****
module ebi_far_mem (
    input wire clk_i,
    input wire slow_i,
    input wire comb_i,
    input wire [19:0] addr_i,
    input wire rd_n_i,
    input wire wrl_n_i,
    input wire wrh_n_i,
    input wire [15:0] wdata_i,
    output wire [15:0] rdata_o,
    output wire wait_n_o,
    output logic [15:0] wr_seen_o
);
    logic [15:0] last_q = 16'h0;
    logic [3:0] cnt_q = 4'h0;
    wire strobe = !rd_n_i || !wrl_n_i;
    // Strobe age, last read, lane captures
    always @(posedge clk_i) begin
        cnt_q <= strobe ? cnt_q + {3'h0, cnt_q != 4'hF} : 4'h0;
        if (!rd_n_i)
            last_q <= rdata_o;
        if (!wrl_n_i && (!comb_i || !addr_i[0]))
            wr_seen_o[7:0] <= wdata_i[7:0];
        if (comb_i ? !wrl_n_i && !wrh_n_i : !wrh_n_i)
            wr_seen_o[15:8] <= wdata_i[15:8];
    end
    // Slow device is not ready until six strobe cycles
    assign wait_n_o = !slow_i || cnt_q >= 4'h6;
    // Drive only while read, else inverse of last
    assign rdata_o = rd_n_i ? ~last_q : {~addr_i[7:0], addr_i[7:0]};
endmodule

// ===== tb/external_bus_interface_test.sv
`timescale 1ns/1ns
`include "ebi_consts.vh"
module external_bus_interface_test;
    logic clk_i, rst_i, ext_reset_n_i, wb_we_i, wb_cyc_i, wb_stb_i, slow, comb;
    logic width_select_i, mode_select_pin_i, bus_hold_request_n_i;
    logic [31:0] wb_adr_i, wb_dat_i, q;
    wire [31:0] wb_dat_o;
    wire [15:0] data_o, mem_d, seen_w;
    wire [1:0] data_oe_o;
    wire [19:0] addr_o;
    wire [3:0] chip_select_n_o;
    wire wb_ack_o, write_low_strobe_n_o, write_high_strobe_n_o, read_strobe_n_o;
    wire addr_latch_strobe_o, hold_ack_out_n_o, wait_request_n_i;
    logic [19:0] seen_a;
    logic [3:0] seen_cs;
    logic [7:0] seen_ad;
    int n_fail = 0, n_tests = 0, rd_len = 0, n_ale = 0, i;
    // Shared data lines from both enables
    wire [15:0] data_i = {data_oe_o[1] ? data_o[15:8] : mem_d[15:8],
        data_oe_o[0] ? data_o[7:0] : mem_d[7:0]};
    ebi_core u_ebi_core (.clk_i, .rst_i, .ext_reset_n_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i(4'hF), .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
        .width_select_i, .mode_select_pin_i, .wait_request_n_i, .bus_hold_request_n_i,
        .data_i, .data_o, .data_oe_o, .addr_o, .chip_select_n_o, .write_low_strobe_n_o,
        .write_high_strobe_n_o, .read_strobe_n_o, .addr_latch_strobe_o, .hold_ack_out_n_o);
    ebi_far_mem u_ebi_far_mem (.clk_i, .slow_i(slow), .comb_i(comb), .addr_i(addr_o),
        .rd_n_i(read_strobe_n_o), .wrl_n_i(write_low_strobe_n_o),
        .wrh_n_i(write_high_strobe_n_o), .wdata_i(data_i), .rdata_o(mem_d),
        .wait_n_o(wait_request_n_i), .wr_seen_o(seen_w));
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Address phase capture, strobe length
    always @(posedge clk_i) begin
        if (addr_latch_strobe_o) begin
            seen_a <= addr_o;
            seen_cs <= chip_select_n_o;
            seen_ad <= data_o[7:0];
            n_ale <= n_ale + 1;
        end
        if (!read_strobe_n_o)
            rd_len <= rd_len + 1;
    end
    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic fail_out();
        n_fail++;
        tally_and_finish();
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Single classic bus cycle
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        wb_adr_i <= {24'h0, a};
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (wb_ack_o !== 1'b1)
            fail_out();
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Start access, poll until idle
    task automatic run(input logic [31:0] cmd);
        int k;
        wb(`EBI_REG_CMD, 1'b1, cmd);
        k = 0;
        do begin
            wb(`EBI_REG_STATUS, 1'b0, 32'h0);
            k++;
        end while (q[`EBI_ST_BUSY_BIT] !== 1'b0 && k < 50);
        if (q[`EBI_ST_BUSY_BIT] !== 1'b0)
            fail_out();
    endtask
    task automatic do_reset(input logic w);
        rst_i <= 1'b1;
        width_select_i <= w;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic t_single();
        wb(`EBI_REG_MODE, 1'b0, 32'h0);
        check("mode", q & 32'h3, 32'h0);
        run(32'h3);
        check("refused", q & 32'h20, 32'h20);
        check("no ale", n_ale, 0);
        wb(`EBI_REG_MODE, 1'b1, 32'h1);
        wb(`EBI_REG_MODE, 1'b1, 32'h2);
        wb(`EBI_REG_MODE, 1'b0, 32'h0);
        check("expand", q & 32'h3, 32'h1);
        wb(8'h3C, 1'b0, 32'h0);
        check("unmapped", q, 32'h0);
    endtask
    task automatic t_wr16();
        wb(`EBI_REG_MODE, 1'b0, 32'h0);
        check("mode", q & 32'h3, 32'h3);
        wb(`EBI_REG_CSEN, 1'b0, 32'h0);
        check("csen", q & 32'hF, 32'h1);
        wb(`EBI_REG_CSEN, 1'b1, 32'hF);
        wb(`EBI_REG_MODE, 1'b1, 32'hB);
        wb(`EBI_REG_ADDR, 1'b1, 32'h40012);
        wb(`EBI_REG_WDATA, 1'b1, 32'hBEEF);
        run(32'h7);
        check("addr", seen_a, 32'h40012);
        check("cs", seen_cs, 32'hD);
        check("mux16", seen_ad, 32'h09);
        check("word", seen_w, 32'hBEEF);
        wb(`EBI_REG_ADDR, 1'b1, 32'h40013);
        wb(`EBI_REG_WDATA, 1'b1, 32'h12);
        run(32'h3);
        check("odd", seen_w, 32'h12EF);
    endtask
    task automatic t_comb();
        comb <= 1'b1;
        wb(`EBI_REG_MODE, 1'b1, 32'h7);
        wb(`EBI_REG_ADDR, 1'b1, 32'h80021);
        wb(`EBI_REG_WDATA, 1'b1, 32'h5A);
        run(32'h3);
        check("bhe", seen_w, 32'h5AEF);
        slow <= 1'b1;
        wb(`EBI_REG_ADDR, 1'b1, 32'h80020);
        rd_len = 0;
        run(32'h5);
        slow <= 1'b0;
        check("stretch", rd_len >= 6, 32'h1);
        wb(`EBI_REG_RDATA, 1'b0, 32'h0);
        check("rdata", q & 32'hFFFF, 32'hDF20);
    endtask
    task automatic t_hold();
        bus_hold_request_n_i <= 1'b0;
        for (i = 0; i < 20 && hold_ack_out_n_o !== 1'b0; i++)
            @(posedge clk_i);
        if (hold_ack_out_n_o !== 1'b0)
            fail_out();
        check("hold", hold_ack_out_n_o, 32'h0);
        bus_hold_request_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        check("unhold", hold_ack_out_n_o, 32'h1);
    endtask
    task automatic t_mux8();
        wb(`EBI_REG_STATUS, 1'b0, 32'h0);
        check("width8", q & 32'h2, 32'h2);
        wb(`EBI_REG_MODE, 1'b1, 32'hF);
        wb(`EBI_REG_ADDR, 1'b1, 32'h40);
        n_ale = 0;
        run(32'h5);
        check("beats", n_ale, 32'h2);
        check("mux8", seen_ad, 32'h41);
        wb(`EBI_REG_RDATA, 1'b0, 32'h0);
        check("rdata8", q & 32'hFFFF, 32'h4140);
    endtask
    task automatic t_ext();
        ext_reset_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        ext_reset_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        wb(`EBI_REG_MODE, 1'b0, 32'h0);
        check("pin reset", q & 32'hF, 32'h3);
    endtask
    // Main sequence
    initial begin
        rst_i <= 1'b1;
        ext_reset_n_i <= 1'b1;
        width_select_i <= 1'b0;
        mode_select_pin_i <= 1'b0;
        bus_hold_request_n_i <= 1'b1;
        {slow, comb, wb_we_i, wb_cyc_i, wb_stb_i} <= 5'h0;
        wb_adr_i <= 32'h0;
        wb_dat_i <= 32'h0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        t_single();
        mode_select_pin_i <= 1'b1;
        do_reset(1'b0);
        t_wr16();
        t_comb();
        t_hold();
        do_reset(1'b1);
        t_mux8();
        t_ext();
        tally_and_finish();
    end
endmodule
